// ==== include/dltc_pkg.sv ====
// Constants and types for the dual legacy timer/counter block.
package dltc_pkg;

	// Peripheral clocks per machine cycle and the mode-0 prescaler width.
	localparam int DLTC_MCYCLE_CLKS = 2;
	localparam int DLTC_PRESC_W     = 5;
	localparam int DLTC_BYTE_W      = 8;

	// Register byte offsets.
	localparam logic [3:0] DLTC_OFF_CTRL = 4'h0;
	localparam logic [3:0] DLTC_OFF_STAT = 4'h4;
	localparam logic [3:0] DLTC_OFF_CNT0 = 4'h8;
	localparam logic [3:0] DLTC_OFF_CNT1 = 4'hC;
	localparam int         DLTC_DEC_W    = 4;

	// Control field layout: one byte per timer, same layout in each.
	localparam int DLTC_CTRL_STRIDE = 8;
	localparam int DLTC_MODE_LSB    = 0;
	localparam int DLTC_CT_BIT      = 2;
	localparam int DLTC_RUN_BIT     = 3;

	// Byte lanes of a count register.
	localparam int DLTC_LO_LANE = 0;
	localparam int DLTC_HI_LANE = 1;

	// Bus answers.
	localparam logic [1:0] DLTC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] DLTC_RESP_SLVERR = 2'h2;

	// Operating modes as software encodes them.
	typedef enum logic [1:0] {
		DLTC_MODE_13BIT  = 2'h0,
		DLTC_MODE_16BIT  = 2'h1,
		DLTC_MODE_RELOAD = 2'h2,
		DLTC_MODE_SPLIT  = 2'h3
	} dltc_mode_type;

	// One timer's count: high byte above low byte.
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} dltc_cnt_type;

endpackage : dltc_pkg

// ==== core/dltc_counter.sv ====
// One timer's count bytes and their mode-dependent increment and reload.
`timescale 1ns/1ps
module dltc_counter
	import dltc_pkg::*;
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          inc_lo,
	input  wire logic          inc_hi,
	input  wire dltc_mode_type mode,
	input  wire logic          wr_lo,
	input  wire logic          wr_hi,
	input  wire logic [7:0]    wdata_lo,
	input  wire logic [7:0]    wdata_hi,
	output logic [15:0]        count,
	output logic               ovf_lo,
	output logic               ovf_hi
);

	dltc_cnt_type st_ff;
	dltc_cnt_type nxt_st;

	// Count per mode; a software write to a byte wins over the count in the same cycle.
	always_comb begin
		nxt_st = st_ff;
		ovf_lo = 1'b0;
		ovf_hi = 1'b0;
		case (mode)
			DLTC_MODE_13BIT: begin
				if (inc_lo) begin
					nxt_st.lo[DLTC_PRESC_W-1:0] = st_ff.lo[DLTC_PRESC_W-1:0] + 1'b1;
					if (&st_ff.lo[DLTC_PRESC_W-1:0]) begin
						nxt_st.hi = st_ff.hi + 8'h01;
						ovf_lo    = &st_ff.hi;
					end
				end
			end
			DLTC_MODE_16BIT: begin
				if (inc_lo) begin
					{nxt_st.hi, nxt_st.lo} = st_ff + 16'h0001;
					ovf_lo                 = &st_ff;
				end
			end
			DLTC_MODE_RELOAD: begin
				if (inc_lo) begin
					if (&st_ff.lo) begin
						nxt_st.lo = st_ff.hi;
						ovf_lo    = 1'b1;
					end else begin
						nxt_st.lo = st_ff.lo + 8'h01;
					end
				end
			end
			DLTC_MODE_SPLIT: begin
				// Two unrelated byte counters, each with its own wrap event.
				if (inc_lo) begin
					nxt_st.lo = st_ff.lo + 8'h01;
					ovf_lo    = &st_ff.lo;
				end
				if (inc_hi) begin
					nxt_st.hi = st_ff.hi + 8'h01;
					ovf_hi    = &st_ff.hi;
				end
			end
			default: begin
				nxt_st = st_ff;
			end
		endcase
		if (wr_lo) begin
			nxt_st.lo = wdata_lo;
		end
		if (wr_hi) begin
			nxt_st.hi = wdata_hi;
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign count = st_ff;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	presc_carry_a: assert property (mode == DLTC_MODE_13BIT && inc_lo && !(&st_ff.lo[DLTC_PRESC_W-1:0])
		&& !wr_hi
		|=> st_ff.hi == $past(st_ff.hi)) else $error("Mode 0 high byte moved without prescaler carry.");
	carry_16_a: assert property (mode == DLTC_MODE_16BIT && inc_lo && !wr_lo && !wr_hi
		|=> st_ff == $past(st_ff) + 16'h0001) else $error("Mode 1 did not count as 16 bits.");
	reload_a: assert property (mode == DLTC_MODE_RELOAD && inc_lo && st_ff.lo == 8'hFF && !wr_lo
		|=> st_ff.lo == $past(st_ff.hi)) else $error("Mode 2 low byte not reloaded.");
	split_lo_a: assert property (mode == DLTC_MODE_SPLIT && inc_hi && !inc_lo && !wr_lo
		|=> $stable(st_ff.lo)) else $error("Split high counting disturbed low byte.");

endmodule : dltc_counter

// ==== core/dltc_timer.sv ====
// Dual legacy timer/counter with its AXI4-Lite register slave.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dltc_timer
	import dltc_pkg::*;
#(
	parameter int ADDR_W      = 8,
	parameter int MCYCLE_CLKS = DLTC_MCYCLE_CLKS
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              timer_zero_count_input,
	input  wire logic              timer_one_count_input,
	output logic [1:0]             overflow_flags
);

	// Parameters the logic cannot serve are refused at elaboration.
	if (ADDR_W <= DLTC_DEC_W || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 32.");
	end
	if (MCYCLE_CLKS < 2) begin : g_bad_mcycle
		$error("MCYCLE_CLKS must be at least 2.");
	end

	// The divider counts clocks inside one machine cycle.
	localparam int              DIV_W    = $clog2(MCYCLE_CLKS);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MCYCLE_CLKS - 1);

	// Block state in one record, so that one register process holds all of it except the count bytes, which each dltc_counter keeps.
	typedef struct packed {
		logic [1:0][1:0]   mode;
		logic [1:0]        ct;
		logic [1:0]        run;
		logic [1:0]        ovf;
		logic [1:0]        pin_prev;
		logic [DIV_W-1:0]  div;
		logic              aw_hold;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_hold;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} dltc_state_type;

	// State, its next value and the combinational helpers taken from it and the pins.
	dltc_state_type   st_ff;
	dltc_state_type   nxt_st;
	logic             tick;
	logic [1:0]       fall;
	logic [1:0]       inc_lo;
	logic [1:0]       inc_hi;
	logic [1:0]       wr_lo;
	logic [1:0]       wr_hi;
	logic [1:0]       ovf_lo;
	logic [1:0]       ovf_hi;
	logic [1:0][15:0] cnt;
	logic [1:0]       set;
	logic [1:0]       clr;
	logic             do_wr;
	logic             w_hit;
	logic [3:0]       w_off;
	logic             r_hit;
	logic [3:0]       r_off;

	// Machine-cycle tick: one clock in every MCYCLE_CLKS.
	assign tick = (st_ff.div == DIV_LAST);

	// Count inputs are synchronous; a falling edge is high last clock and low now.
	assign fall = st_ff.pin_prev & ~{timer_one_count_input, timer_zero_count_input};

	// A write is carried out once address and data are both held and no answer is pending.
	assign do_wr = st_ff.aw_hold & st_ff.w_hold & ~st_ff.bvalid;
	assign w_hit = ~|st_ff.aw_addr[ADDR_W-1:DLTC_DEC_W];
	assign w_off = {st_ff.aw_addr[DLTC_DEC_W-1:2], 2'b00};
	assign r_hit = ~|s_axi_araddr[ADDR_W-1:DLTC_DEC_W];
	assign r_off = {s_axi_araddr[DLTC_DEC_W-1:2], 2'b00};

	// Timer zero wraps set flag zero; timer one wraps, or the split high byte wraps, set flag one.
	assign set = {ovf_lo[1] | ovf_hi[0], ovf_lo[0]};

	// Per-timer event steering and count unit; no state is shared outside split mode.
	for (genvar i = 0; i < 2; i++) begin : g_tmr
		localparam logic [3:0] CNT_OFF = (i == 0) ? DLTC_OFF_CNT0 : DLTC_OFF_CNT1;
		logic split_frozen;
		logic own_split;

		assign split_frozen = (i == 1) && (st_ff.mode[i] == DLTC_MODE_SPLIT);
		assign own_split    = (i == 0) && (st_ff.mode[i] == DLTC_MODE_SPLIT);

		// Timer function takes the machine tick, counter function the falling edge.
		assign inc_lo[i] = st_ff.run[i] & (st_ff.ct[i] ? fall[i] : tick) & ~split_frozen;
		// In split mode the high byte of timer zero borrows timer one's run bit.
		assign inc_hi[i] = own_split & st_ff.run[1] & tick;

		assign wr_lo[i] = do_wr & w_hit & (w_off == CNT_OFF) & st_ff.w_strb[DLTC_LO_LANE];
		assign wr_hi[i] = do_wr & w_hit & (w_off == CNT_OFF) & st_ff.w_strb[DLTC_HI_LANE];
		assign clr[i]   = do_wr & w_hit & (w_off == DLTC_OFF_STAT) & st_ff.w_strb[0] & st_ff.w_data[i];

		dltc_counter u_cnt (
			.aclk     (aclk),
			.aresetn  (aresetn),
			.inc_lo   (inc_lo[i]),
			.inc_hi   (inc_hi[i]),
			.mode     (dltc_mode_type'(st_ff.mode[i])),
			.wr_lo    (wr_lo[i]),
			.wr_hi    (wr_hi[i]),
			.wdata_lo (st_ff.w_data[DLTC_LO_LANE*DLTC_BYTE_W +: DLTC_BYTE_W]),
			.wdata_hi (st_ff.w_data[DLTC_HI_LANE*DLTC_BYTE_W +: DLTC_BYTE_W]),
			.count    (cnt[i]),
			.ovf_lo   (ovf_lo[i]),
			.ovf_hi   (ovf_hi[i])
		);
	end

	// Next state: divider, edge history, flags, control writes and both bus channels.
	always_comb begin
		logic [31:0] rd;
		rd     = '0;
		nxt_st = st_ff;

		// Divider and pin history run on every clock, whatever the run bits say.
		nxt_st.div      = tick ? '0 : st_ff.div + 1'b1;
		nxt_st.pin_prev = {timer_one_count_input, timer_zero_count_input};

		// A wrap in the same cycle as a clearing write keeps the flag set.
		nxt_st.ovf = (st_ff.ovf & ~clr) | set;

		// Control byte per timer, each behind its own strobe.
		if (do_wr && w_hit && w_off == DLTC_OFF_CTRL) begin
			for (int i = 0; i < 2; i++) begin
				if (st_ff.w_strb[i]) begin
					nxt_st.mode[i] = st_ff.w_data[i*DLTC_CTRL_STRIDE+DLTC_MODE_LSB +: 2];
					nxt_st.ct[i]   = st_ff.w_data[i*DLTC_CTRL_STRIDE+DLTC_CT_BIT];
					nxt_st.run[i]  = st_ff.w_data[i*DLTC_CTRL_STRIDE+DLTC_RUN_BIT];
				end
			end
		end

		// Write address and data are taken independently, in either order.
		if (st_ff.awready && s_axi_awvalid) begin
			nxt_st.aw_hold = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (st_ff.wready && s_axi_wvalid) begin
			nxt_st.w_hold = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		if (do_wr) begin
			nxt_st.aw_hold = 1'b0;
			nxt_st.w_hold  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			nxt_st.bresp   = w_hit ? DLTC_RESP_OKAY : DLTC_RESP_SLVERR;
		end else if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// No new write is taken until the previous answer has gone.
		nxt_st.awready = ~nxt_st.aw_hold & ~nxt_st.bvalid;
		nxt_st.wready  = ~nxt_st.w_hold & ~nxt_st.bvalid;

		// Read data are sampled at the accepting edge, so they show the state of that cycle.
		case (r_off)
			DLTC_OFF_CTRL: begin
				for (int i = 0; i < 2; i++) begin
					rd[i*DLTC_CTRL_STRIDE+DLTC_MODE_LSB +: 2] = st_ff.mode[i];
					rd[i*DLTC_CTRL_STRIDE+DLTC_CT_BIT]       = st_ff.ct[i];
					rd[i*DLTC_CTRL_STRIDE+DLTC_RUN_BIT]      = st_ff.run[i];
				end
			end
			DLTC_OFF_STAT: rd[1:0] = st_ff.ovf;
			DLTC_OFF_CNT0: rd[15:0] = cnt[0];
			DLTC_OFF_CNT1: rd[15:0] = cnt[1];
			default: rd = '0;
		endcase
		// One read at a time: the address is only taken while no answer waits.
		if (st_ff.arready && s_axi_arvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = r_hit ? rd : '0;
			nxt_st.rresp  = r_hit ? DLTC_RESP_OKAY : DLTC_RESP_SLVERR;
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		nxt_st.arready = ~nxt_st.rvalid;
	end

	// State register; everything starts stopped, in mode 0, with flags clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Every output is a register bit.
	assign s_axi_awready  = st_ff.awready;
	assign s_axi_wready   = st_ff.wready;
	assign s_axi_bresp    = st_ff.bresp;
	assign s_axi_bvalid   = st_ff.bvalid;
	assign s_axi_arready  = st_ff.arready;
	assign s_axi_rdata    = st_ff.rdata;
	assign s_axi_rresp    = st_ff.rresp;
	assign s_axi_rvalid   = st_ff.rvalid;
	assign overflow_flags = st_ff.ovf;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// The exact period check only holds for the documented divide by two.
	if (MCYCLE_CLKS == 2) begin : g_period_chk
		tick_period_a: assert property (tick |=> !tick ##1 tick)
			else $error("Machine tick is not every second clock.");
	end

	// Two clean cycles in a row must hold exactly one machine tick.
	timer_step_a: assert property ((st_ff.run[0] && !st_ff.ct[0] && st_ff.mode[0] == DLTC_MODE_16BIT
		&& !wr_lo[0] && !wr_hi[0]) [*2]
		|=> cnt[0] == $past(cnt[0], 2) + 16'h0001) else $error("Timer zero did not step once in two clocks.");

	// Counter function: only a high-then-low pin sample moves the count.
	edge_count_a: assert property (st_ff.run[1] && st_ff.ct[1] && st_ff.mode[1] == DLTC_MODE_16BIT
		&& !wr_lo[1] && !wr_hi[1] && st_ff.pin_prev[1] == timer_one_count_input
		|=> $stable(cnt[1])) else $error("Counter moved without a falling edge.");

	edge_hit_a: assert property (st_ff.run[1] && st_ff.ct[1] && st_ff.mode[1] == DLTC_MODE_16BIT
		&& !wr_lo[1] && !wr_hi[1] && st_ff.pin_prev[1] && !timer_one_count_input
		|=> cnt[1] == $past(cnt[1]) + 16'h0001) else $error("Falling edge not counted.");

	split_high_a: assert property (st_ff.mode[0] == DLTC_MODE_SPLIT && st_ff.run[1] && tick && !wr_hi[0]
		|=> cnt[0][15:8] == $past(cnt[0][15:8]) + 8'h01) else $error("Split high byte did not count.");

	freeze_one_a: assert property (st_ff.mode[1] == DLTC_MODE_SPLIT && !wr_lo[1] && !wr_hi[1]
		|=> $stable(cnt[1])) else $error("Timer one moved in mode 3.");

	indep_zero_a: assert property (st_ff.mode[0] != DLTC_MODE_SPLIT && !st_ff.run[0]
		&& !wr_lo[0] && !wr_hi[0] |=> $stable(cnt[0])) else $error("Stopped timer zero moved.");

	// A flag survives until software clears it; a clear in its first cycle may drop it.
	flag_set_a: assert property (set[0] |=> st_ff.ovf[0] ##1 (st_ff.ovf[0] || $past(clr[0])))
		else $error("Overflow flag lost after a wrap.");

	// Bus answers come one cycle after the request is complete.
	write_answer_a: assert property (do_wr |=> s_axi_bvalid && !s_axi_awready)
		else $error("Write answer not raised one cycle after the write.");

	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("Read answer not raised one cycle after acceptance.");

	// Split mode: the high byte wrap of timer zero lands in flag one.
	split_flag_a: assert property (st_ff.mode[0] == DLTC_MODE_SPLIT && inc_hi[0] && &cnt[0][15:8]
		&& !wr_hi[0] |=> st_ff.ovf[1]) else $error("Split high wrap did not set flag one.");

	// A frozen timer one must never raise a wrap of its own.
	frozen_wrap_a: assert property (st_ff.mode[1] == DLTC_MODE_SPLIT |-> !ovf_lo[1])
		else $error("Frozen timer one reported a wrap.");

	// Timer zero in counter function takes the falling edges of its own pin.
	zero_edge_a: assert property (st_ff.run[0] && st_ff.ct[0] && st_ff.mode[0] == DLTC_MODE_16BIT
		&& !wr_lo[0] && !wr_hi[0] && st_ff.pin_prev[0] && !timer_zero_count_input
		|=> cnt[0] == $past(cnt[0]) + 16'h0001) else $error("Timer zero falling edge not counted.");

	// Outside split mode a stopped timer one keeps its count.
	indep_one_a: assert property (st_ff.mode[1] != DLTC_MODE_SPLIT && !st_ff.run[1]
		&& !wr_lo[1] && !wr_hi[1] |=> $stable(cnt[1])) else $error("Stopped timer one moved.");

	// Answers stand unchanged until the master takes them.
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write answer dropped before it was taken.");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read answer changed before it was taken.");

	// Main scenarios the bench is expected to reach.
	wrap_flag_c: cover property (set[0] ##1 st_ff.ovf[0]);
	split_wrap_c: cover property (st_ff.mode[0] == DLTC_MODE_SPLIT && ovf_hi[0]);
	write_done_c: cover property (do_wr ##1 s_axi_bvalid && s_axi_bready);
	reload_c: cover property (st_ff.mode[1] == DLTC_MODE_RELOAD && ovf_lo[1]);
	freeze_c: cover property (st_ff.mode[1] == DLTC_MODE_SPLIT && st_ff.run[1] && fall[1]);

endmodule : dltc_timer

// ==== tb/dual_legacy_timer_counter_bench.sv ====
// Self-checking bench for the dual legacy timer/counter over its AXI4-Lite registers.
`timescale 1ns/1ps
module dual_legacy_timer_counter_bench;
	import dltc_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin0, pin1;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, flags, resp;
	int          bad_count, compares, cyc, t1, t2;
	logic [31:0] v1;

	dltc_timer u_dltc_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_zero_count_input(pin0),
		.timer_one_count_input(pin1), .overflow_flags(flags));

	// The clock toggles every half period of 2.5 ns.
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Free cycle count, used to measure the span between two count snapshots.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
	end

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask : check

	// Waits are bounded; running out counts as a mismatch and ends the run.
	task automatic timed_out(input string what);
		$display("wrong value %s expected handshake seen none", what);
		bad_count++;
		test_done();
	endtask : timed_out

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int  n;
		logic aw_done, w_done;
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hF;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw_done = 1'b0;
		w_done  = 1'b0;
		n = 0;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (wvalid && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
			if (++n > 50) timed_out("write address or data");
		end
		n = 0;
		do begin
			@(posedge aclk);
			if (++n > 50) timed_out("write response");
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (++n > 50) timed_out("read address");
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		n = 0;
		while (rvalid !== 1'b1) begin
			@(posedge aclk);
			if (++n > 50) timed_out("read data");
		end
		d = rdata;
		r = rresp;
		t2 = cyc;
		rready <= 1'b0;
	endtask : axi_read

	// Writes a register and expects an OKAY answer.
	task automatic wr(input logic [3:0] off, input logic [31:0] d);
		axi_write({4'h0, off}, d, resp);
		check("write response", {30'h0, DLTC_RESP_OKAY}, {30'h0, resp});
	endtask : wr

	// Reads a register, compares the masked word and the answer code.
	task automatic rd_chk(input string name, input logic [3:0] off, input logic [31:0] mask, input logic [31:0] exp);
		axi_read({4'h0, off}, rd, resp);
		check(name, exp & mask, rd & mask);
		check("read response", {30'h0, DLTC_RESP_OKAY}, {30'h0, resp});
	endtask : rd_chk

	// Falling edges on a count pin: low one cycle, high one cycle.
	task automatic pulse(input logic p0, input logic p1, input int n);
		repeat (n) begin
			@(posedge aclk);
			pin0 <= ~p0;
			pin1 <= ~p1;
			@(posedge aclk);
			pin0 <= 1'b1;
			pin1 <= 1'b1;
		end
		repeat (3) @(posedge aclk);
	endtask : pulse

	function automatic logic [31:0] ctl(input logic [1:0] m0, input logic c0, input logic r0,
		input logic [1:0] m1, input logic c1, input logic r1);
		logic [31:0] v;
		v = 32'h0;
		v[DLTC_MODE_LSB +: 2] = m0;
		v[DLTC_CT_BIT] = c0;
		v[DLTC_RUN_BIT] = r0;
		v[DLTC_CTRL_STRIDE + DLTC_MODE_LSB +: 2] = m1;
		v[DLTC_CTRL_STRIDE + DLTC_CT_BIT] = c1;
		v[DLTC_CTRL_STRIDE + DLTC_RUN_BIT] = r1;
		return v;
	endfunction : ctl

	// Clears both overflow flags and confirms the pin view follows.
	task automatic clear_flags;
		wr(DLTC_OFF_STAT, 32'h0000_0003);
		check("flag pins", 32'h0, {30'h0, flags});
	endtask : clear_flags

	task automatic t_reset;
		rd_chk("control", DLTC_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
		rd_chk("status", DLTC_OFF_STAT, 32'hFFFF_FFFF, 32'h0);
		rd_chk("count zero", DLTC_OFF_CNT0, 32'hFFFF_FFFF, 32'h0);
		rd_chk("count one", DLTC_OFF_CNT1, 32'hFFFF_FFFF, 32'h0);
		axi_read(8'h10, rd, resp);
		check("unmapped read data", 32'h0, rd);
		check("unmapped read response", {30'h0, DLTC_RESP_SLVERR}, {30'h0, resp});
		axi_write(8'h10, 32'hFFFF_FFFF, resp);
		check("unmapped write", {30'h0, DLTC_RESP_SLVERR}, {30'h0, resp});
		rd_chk("control after unmapped write", DLTC_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
	endtask : t_reset

	// Timer function: one step per two clocks, nothing while stopped.
	task automatic t_rate;
		wr(DLTC_OFF_CNT1, 32'h0);
		wr(DLTC_OFF_CTRL, ctl(2'h1, 1'b0, 1'b1, 2'h1, 1'b0, 1'b1));
		rd_chk("control readback", DLTC_OFF_CTRL, 32'hFFFF_FFFF, ctl(2'h1, 1'b0, 1'b1, 2'h1, 1'b0, 1'b1));
		axi_read({4'h0, DLTC_OFF_CNT1}, v1, resp);
		t1 = t2;
		repeat (40) @(posedge aclk);
		axi_read({4'h0, DLTC_OFF_CNT1}, rd, resp);
		compares++;
		if ((2 * int'(rd[15:0] - v1[15:0])) - (t2 - t1) > 1 || (2 * int'(rd[15:0] - v1[15:0])) - (t2 - t1) < -1) begin
			$display("wrong value timer rate expected %0d seen %0d", (t2 - t1) / 2, rd[15:0] - v1[15:0]);
			bad_count++;
		end
		wr(DLTC_OFF_CTRL, ctl(2'h1, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0));
		axi_read({4'h0, DLTC_OFF_CNT1}, v1, resp);
		repeat (20) @(posedge aclk);
		rd_chk("stopped count", DLTC_OFF_CNT1, 32'hFFFF, v1);
	endtask : t_rate

	// Mode 0: five-bit prescaler feeds the high byte, low[7:5] untouched.
	task automatic t_mode0;
		wr(DLTC_OFF_CTRL, ctl(2'h0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0));
		wr(DLTC_OFF_CNT0, 32'h0000_FFFE);
		pulse(1'b1, 1'b0, 1);
		rd_chk("mode 0 step", DLTC_OFF_CNT0, 32'hFFFF, 32'h0000_FFFF);
		check("flag pins before wrap", 32'h0, {30'h0, flags});
		pulse(1'b1, 1'b0, 1);
		rd_chk("mode 0 wrap", DLTC_OFF_CNT0, 32'hFFFF, 32'h0000_00E0);
		rd_chk("mode 0 flag", DLTC_OFF_STAT, 32'h3, 32'h1);
		check("flag pins after wrap", 32'h1, {30'h0, flags});
		clear_flags();
	endtask : t_mode0

	// Mode 1 on both timers with different edge counts on each pin.
	task automatic t_mode1;
		wr(DLTC_OFF_CTRL, ctl(2'h1, 1'b1, 1'b1, 2'h1, 1'b1, 1'b1));
		wr(DLTC_OFF_CNT0, 32'h0000_00FF);
		wr(DLTC_OFF_CNT1, 32'h0000_FFFE);
		pulse(1'b1, 1'b1, 1);
		pulse(1'b0, 1'b1, 1);
		rd_chk("mode 1 carry", DLTC_OFF_CNT0, 32'hFFFF, 32'h0000_0100);
		rd_chk("mode 1 wrap", DLTC_OFF_CNT1, 32'hFFFF, 32'h0);
		rd_chk("mode 1 flags", DLTC_OFF_STAT, 32'h3, 32'h2);
		clear_flags();
	endtask : t_mode1

	// Mode 2: the low byte reloads from the high byte when it wraps.
	task automatic t_mode2;
		wr(DLTC_OFF_CTRL, ctl(2'h2, 1'b1, 1'b1, 2'h2, 1'b1, 1'b1));
		wr(DLTC_OFF_CNT0, 32'h0000_80FE);
		wr(DLTC_OFF_CNT1, 32'h0000_40FE);
		pulse(1'b1, 1'b1, 2);
		rd_chk("mode 2 reload", DLTC_OFF_CNT0, 32'hFFFF, 32'h0000_8080);
		rd_chk("mode 2 reload one", DLTC_OFF_CNT1, 32'hFFFF, 32'h0000_4040);
		check("mode 2 flag pins", 32'h3, {30'h0, flags});
		pulse(1'b1, 1'b0, 1);
		rd_chk("mode 2 after reload", DLTC_OFF_CNT0, 32'hFFFF, 32'h0000_8081);
		rd_chk("mode 2 timer one untouched", DLTC_OFF_CNT1, 32'hFFFF, 32'h0000_4040);
		clear_flags();
	endtask : t_mode2

	// Mode 3: timer zero splits in two, timer one holds its count.
	task automatic t_mode3;
		wr(DLTC_OFF_CNT0, 32'h0000_FC00);
		wr(DLTC_OFF_CNT1, 32'h0000_1234);
		wr(DLTC_OFF_CTRL, ctl(2'h3, 1'b1, 1'b1, 2'h3, 1'b1, 1'b0));
		pulse(1'b1, 1'b1, 3);
		rd_chk("split low byte", DLTC_OFF_CNT0, 32'hFFFF, 32'h0000_FC03);
		wr(DLTC_OFF_CTRL, ctl(2'h3, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1));
		pulse(1'b1, 1'b1, 2);
		rd_chk("frozen timer one", DLTC_OFF_CNT1, 32'hFFFF, 32'h0000_1234);
		rd_chk("split low independent", DLTC_OFF_CNT0, 32'hFF, 32'h05);
		// About six ticks pass with run one set, so the high byte has wrapped past FF but not far.
		check("split high wrapped", 32'h1, {31'h0, rd[15:8] < 8'h10});
		check("split high flag", 32'h2, {30'h0, flags});
		wr(DLTC_OFF_CTRL, 32'h0);
		clear_flags();
	endtask : t_mode3

	// Main sequence: all inputs defined at time zero, reset for six cycles.
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		pin0 = 1'b1;
		pin1 = 1'b1;
		cyc = 0;
		bad_count = 0;
		compares = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_rate();
		t_mode0();
		t_mode1();
		t_mode2();
		t_mode3();
		test_done();
	end
endmodule : dual_legacy_timer_counter_bench
